// ---- src/brhz_defines.svh ----
// Constants of the branch and register hazard control block
`ifndef BRHZ_DEFINES_SVH
`define BRHZ_DEFINES_SVH

// Widths
`define BRHZ_AW 24
`define BRHZ_WW 32
`define BRHZ_LCW 32

// Program counter
`define BRHZ_RESET_PC 24'h000000
`define BRHZ_PC_STEP 24'h000001

// Predecoded word layout
`define BRHZ_OP_MSB 31
`define BRHZ_OP_LSB 28
`define BRHZ_USE_MSB 27
`define BRHZ_USE_LSB 25
`define BRHZ_WR_MSB 24
`define BRHZ_WR_LSB 22
`define BRHZ_RD_AUX 18
`define BRHZ_RD_IDX 19
`define BRHZ_RD_DP 20
`define BRHZ_RD_SP 21

// Register group positions in a group mask
`define BRHZ_G_AUX 0
`define BRHZ_G_DP 1
`define BRHZ_G_SP 2

// Operation codes
`define BRHZ_OP_NORMAL 4'h0
`define BRHZ_OP_JUMP 4'h1
`define BRHZ_OP_CJUMP 4'h2
`define BRHZ_OP_CDCJ 4'h3
`define BRHZ_OP_CALL 4'h4
`define BRHZ_OP_HALT 4'h5
`define BRHZ_OP_BLKRPT 4'h6
`define BRHZ_OP_SGLRPT 4'h7
`define BRHZ_OP_RETI 4'h8
`define BRHZ_OP_RETS 4'h9
`define BRHZ_OP_JUMPD 4'ha
`define BRHZ_OP_CJUMPD 4'hb
`define BRHZ_OP_CDCJD 4'hc
`define BRHZ_OP_CDJ 4'hd

// Delay slots after a delayed jump
`define BRHZ_DLY_SLOTS 2'h3
`define BRHZ_DLY_LAST 2'h1
`define BRHZ_DLY_NONE 2'h0

`endif

// ---- src/brhz_pkg.sv ----
// Types of the branch and register hazard control block
package brhz_pkg;

  typedef enum logic [2:0] {
    cls_normal,
    cls_flush,
    cls_repeat,
    cls_halt,
    cls_delayed
  } brhz_cls_t;

  typedef struct packed {
    brhz_cls_t cls;
    logic [2:0] use_grp;
    logic [2:0] wr_grp;
    logic [2:0] rd_grp;
    logic irq;
  } brhz_info_t;

endpackage

// ---- src/brhz_dec_if.sv ----
// Carrier between the controller and its predecoder
`timescale 1ns/100ps
interface brhz_dec_if;
  logic [31:0] word;
  brhz_pkg::brhz_info_t info;
  modport ctl (output word, input info);
  modport dec (input word, output info);
endinterface

// ---- src/brhz_predecode.sv ----
// Predecoder: class and register group masks of a program word
`timescale 1ns/100ps
`include "brhz_defines.svh"
module brhz_predecode (
  // Word in, class and masks out
  brhz_dec_if.dec bus
);

  logic [3:0] op;

  assign op = bus.word[`BRHZ_OP_MSB:`BRHZ_OP_LSB];

  // Class and group masks
  always_comb begin
    bus.info = '0;
    bus.info.use_grp = bus.word[`BRHZ_USE_MSB:`BRHZ_USE_LSB];
    bus.info.wr_grp = bus.word[`BRHZ_WR_MSB:`BRHZ_WR_LSB];
    // Index, block size and page pointer reads never stall
    bus.info.rd_grp[`BRHZ_G_AUX] = bus.word[`BRHZ_RD_AUX];
    bus.info.rd_grp[`BRHZ_G_SP] = bus.word[`BRHZ_RD_SP];
    unique case (op)
      `BRHZ_OP_NORMAL: bus.info.cls = brhz_pkg::cls_normal;
      `BRHZ_OP_JUMP, `BRHZ_OP_CJUMP, `BRHZ_OP_CALL,
      `BRHZ_OP_RETI, `BRHZ_OP_RETS: bus.info.cls = brhz_pkg::cls_flush;
      `BRHZ_OP_HALT: bus.info.cls = brhz_pkg::cls_halt;
      `BRHZ_OP_BLKRPT, `BRHZ_OP_SGLRPT: bus.info.cls = brhz_pkg::cls_repeat;
      `BRHZ_OP_JUMPD, `BRHZ_OP_CJUMPD: bus.info.cls = brhz_pkg::cls_delayed;
      `BRHZ_OP_CDCJ, `BRHZ_OP_CDJ: begin
        // Loop counter pointer counts as address generation
        bus.info.cls = brhz_pkg::cls_flush;
        bus.info.use_grp[`BRHZ_G_AUX] = 1'b1;
        bus.info.rd_grp[`BRHZ_G_AUX] = 1'b1;
        bus.info.wr_grp[`BRHZ_G_AUX] = 1'b1;
      end
      `BRHZ_OP_CDCJD: begin
        bus.info.cls = brhz_pkg::cls_delayed;
        bus.info.use_grp[`BRHZ_G_AUX] = 1'b1;
        bus.info.rd_grp[`BRHZ_G_AUX] = 1'b1;
        bus.info.wr_grp[`BRHZ_G_AUX] = 1'b1;
      end
      default: bus.info.cls = brhz_pkg::cls_normal;
    endcase
  end

endmodule

// ---- src/brhz_ctl.sv ----
// Pipeline controller: branch flushes, delayed jumps, register group stalls
// Contract
// - Flushing jumps, calls, halt, repeats, returns, interrupts and reset empty the pipe.
// - A flushing jump makes one dummy fetch that still reaches the cache.
// - Repeat instructions flush; plain moves into loop registers never flush.
// - Outside repeat mode loop registers are plain 32-bit registers, no stall.
// - Up to four words precede repeat mode; software follows direct loads with jump.
// - A direct loop count write beats the repeat logic update in one cycle.
// - Delayed jumps never flush; three following words run, then the target.
// - Groups: pointers with index and block size; page pointer; stack pointer.
// - Decode using a group waits until an earlier writer of it finishes execute.
// - A group write right before a group user holds that decode two cycles.
// - Every stalled decode cycle refetches the next word; a stalled flushing op makes it a dummy fetch.
// - A group read in the read stage delays the next user's decode exactly one cycle.
// - Index, block size and page pointer reads cause no read stall.
// - Count-down jump pointer use triggers the same write and read stalls.
// - Each instruction passes fetch, decode, read, execute in order, one per cycle.
// - Execute beats read beats decode beats fetch; lower units wait.
`timescale 1ns/100ps
`include "brhz_defines.svh"
module brhz_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Program fetch port
  input wire logic [`BRHZ_WW-1:0] pm_rdata,
  input wire logic pm_ready,
  output logic fetch_req_q,
  output logic [`BRHZ_AW-1:0] fetch_addr_q,
  output logic fetch_dummy_q,
  // Execute stage
  input wire logic br_taken,
  input wire logic [`BRHZ_AW-1:0] br_target,
  output logic exec_valid_q,
  output logic [`BRHZ_WW-1:0] exec_word_q,
  // Interrupts and halt
  input wire logic irq_req,
  input wire logic [`BRHZ_AW-1:0] irq_vector,
  output logic irq_ack_q,
  output logic halted_q,
  // Repeat and loop count
  input wire logic lc_wr,
  input wire logic [`BRHZ_LCW-1:0] lc_wdata,
  input wire logic lc_rpt_upd,
  input wire logic [`BRHZ_LCW-1:0] lc_rpt_data,
  output logic rpt_load_q,
  output logic [`BRHZ_LCW-1:0] loop_count_q
);

  // Flushing classes
  function automatic logic is_flush(brhz_pkg::brhz_cls_t c);
    return (c == brhz_pkg::cls_flush) || (c == brhz_pkg::cls_repeat) ||
           (c == brhz_pkg::cls_halt);
  endfunction

  // Group overlap of a stage against the decode user
  function automatic logic grp_hit(logic v, logic [2:0] a, logic [2:0] b);
    return v && ((a & b) != 3'h0);
  endfunction

  function automatic logic [`BRHZ_AW-1:0] inc_pc(logic [`BRHZ_AW-1:0] p);
    return p + `BRHZ_PC_STEP;
  endfunction

  brhz_dec_if dec_bus ();
  brhz_predecode u_predecode (
    .bus (dec_bus)
  );

  logic d_valid_q, d_valid_d, r_valid_q, r_valid_d, exec_valid_d;
  logic [`BRHZ_WW-1:0] d_word_q, d_word_d, r_word_q, r_word_d, exec_word_d;
  logic [`BRHZ_AW-1:0] d_pc_q, d_pc_d, r_pc_q, r_pc_d, e_pc_q, e_pc_d;
  brhz_pkg::brhz_info_t d_info_q, d_info_d, r_info_q, r_info_d, e_info_q, e_info_d;
  brhz_pkg::brhz_info_t irq_info;
  logic [`BRHZ_AW-1:0] fetch_addr_d, irq_vec_q, irq_vec_d, dly_tgt_q, dly_tgt_d;
  logic fetch_req_d, fetch_dummy_d, irq_ack_d, halted_d, rpt_load_d;
  logic dly_tgt_v_q, dly_tgt_v_d, eff_tgt_v;
  logic [1:0] dly_cnt_q, dly_cnt_d;
  logic [`BRHZ_AW-1:0] eff_tgt;
  logic [`BRHZ_LCW-1:0] loop_count_d;
  logic wr_hit, rd_hit, stall, d_adv, d_free, take, discard, inject, e_flush;

  assign dec_bus.word = pm_rdata;

  // Hazard detection against read and execute stages
  assign wr_hit = grp_hit(r_valid_q, r_info_q.wr_grp, d_info_q.use_grp) ||
                  grp_hit(exec_valid_q, e_info_q.wr_grp, d_info_q.use_grp);
  assign rd_hit = grp_hit(r_valid_q, r_info_q.rd_grp, d_info_q.use_grp);
  assign stall = d_valid_q && (wr_hit || rd_hit);
  assign d_adv = d_valid_q && !stall;
  assign d_free = !d_valid_q || d_adv;
  // Fetch completes only when decode can take the word
  assign take = fetch_req_q && pm_ready && d_free;
  assign discard = d_valid_q && is_flush(d_info_q.cls);
  assign inject = irq_req && !discard && (dly_cnt_q == `BRHZ_DLY_NONE);
  assign e_flush = exec_valid_q && is_flush(e_info_q.cls);
  assign eff_tgt_v = dly_tgt_v_q ||
                     (exec_valid_q && e_info_q.cls == brhz_pkg::cls_delayed && br_taken);
  assign eff_tgt = dly_tgt_v_q ? dly_tgt_q : br_target;

  // Next state of stages, program counter and control
  always_comb begin
    irq_info = '0;
    irq_info.cls = brhz_pkg::cls_flush;
    irq_info.irq = 1'b1;
    // Read and execute always move on
    exec_valid_d = r_valid_q;
    exec_word_d = r_word_q;
    e_pc_d = r_pc_q;
    e_info_d = r_info_q;
    r_valid_d = d_adv;
    r_word_d = d_word_q;
    r_pc_d = d_pc_q;
    r_info_d = d_info_q;
    d_valid_d = d_valid_q && stall;
    d_word_d = d_word_q;
    d_pc_d = d_pc_q;
    d_info_d = d_info_q;
    fetch_addr_d = fetch_addr_q;
    irq_vec_d = irq_vec_q;
    irq_ack_d = 1'b0;
    halted_d = halted_q;
    rpt_load_d = 1'b0;
    dly_cnt_d = dly_cnt_q;
    dly_tgt_v_d = dly_tgt_v_q;
    dly_tgt_d = dly_tgt_q;
    // Fetch into decode; a word behind a flushing op is thrown away
    if (take) begin
      if (inject) begin
        d_valid_d = 1'b1;
        d_word_d = '0;
        d_pc_d = fetch_addr_q;
        d_info_d = irq_info;
        irq_vec_d = irq_vector;
        irq_ack_d = 1'b1;
      end else begin
        fetch_addr_d = inc_pc(fetch_addr_q);
        if (!discard) begin
          d_valid_d = 1'b1;
          d_word_d = pm_rdata;
          d_pc_d = fetch_addr_q;
          d_info_d = dec_bus.info;
          if (dly_cnt_q != `BRHZ_DLY_NONE) begin
            dly_cnt_d = dly_cnt_q - `BRHZ_DLY_LAST;
          end
          if (dec_bus.info.cls == brhz_pkg::cls_delayed) begin
            dly_cnt_d = `BRHZ_DLY_SLOTS;
          end
        end
      end
    end
    // Delayed jump target, latched at execute
    if (exec_valid_q && e_info_q.cls == brhz_pkg::cls_delayed && br_taken) begin
      dly_tgt_v_d = 1'b1;
      dly_tgt_d = br_target;
    end
    // Redirect after the third delay slot word is fetched
    if (take && !inject && !discard && dly_cnt_q == `BRHZ_DLY_LAST) begin
      dly_tgt_v_d = 1'b0;
      if (eff_tgt_v) begin
        fetch_addr_d = eff_tgt;
      end
    end
    // Completion of a flushing op at execute
    if (e_flush) begin
      if (e_info_q.irq) begin
        fetch_addr_d = irq_vec_q;
      end else if (e_info_q.cls == brhz_pkg::cls_halt) begin
        fetch_addr_d = inc_pc(e_pc_q);
        halted_d = 1'b1;
      end else if (e_info_q.cls == brhz_pkg::cls_repeat) begin
        fetch_addr_d = inc_pc(e_pc_q);
        rpt_load_d = 1'b1;
      end else begin
        fetch_addr_d = br_taken ? br_target : inc_pc(e_pc_q);
      end
    end
    if (halted_q && irq_req) begin
      halted_d = 1'b0;
    end
    // Fetch idles while a flushing op is in read or execute
    fetch_req_d = !halted_d && !(r_valid_d && is_flush(r_info_d.cls)) &&
                  !(exec_valid_d && is_flush(e_info_d.cls));
    fetch_dummy_d = fetch_req_d && d_valid_d && is_flush(d_info_d.cls);
  end

  // Pipeline registers
  always_ff @(posedge clk) begin
    if (srst) begin
      d_valid_q <= 1'b0;
      r_valid_q <= 1'b0;
      exec_valid_q <= 1'b0;
      d_word_q <= '0;
      r_word_q <= '0;
      exec_word_q <= '0;
      d_pc_q <= `BRHZ_RESET_PC;
      r_pc_q <= `BRHZ_RESET_PC;
      e_pc_q <= `BRHZ_RESET_PC;
      d_info_q <= '0;
      r_info_q <= '0;
      e_info_q <= '0;
      fetch_addr_q <= `BRHZ_RESET_PC;
      fetch_req_q <= 1'b0;
      fetch_dummy_q <= 1'b0;
      irq_vec_q <= `BRHZ_RESET_PC;
      irq_ack_q <= 1'b0;
      halted_q <= 1'b0;
      rpt_load_q <= 1'b0;
      dly_cnt_q <= `BRHZ_DLY_NONE;
      dly_tgt_v_q <= 1'b0;
      dly_tgt_q <= `BRHZ_RESET_PC;
    end else begin
      d_valid_q <= d_valid_d;
      r_valid_q <= r_valid_d;
      exec_valid_q <= exec_valid_d;
      d_word_q <= d_word_d;
      r_word_q <= r_word_d;
      exec_word_q <= exec_word_d;
      d_pc_q <= d_pc_d;
      r_pc_q <= r_pc_d;
      e_pc_q <= e_pc_d;
      d_info_q <= d_info_d;
      r_info_q <= r_info_d;
      e_info_q <= e_info_d;
      fetch_addr_q <= fetch_addr_d;
      fetch_req_q <= fetch_req_d;
      fetch_dummy_q <= fetch_dummy_d;
      irq_vec_q <= irq_vec_d;
      irq_ack_q <= irq_ack_d;
      halted_q <= halted_d;
      rpt_load_q <= rpt_load_d;
      dly_cnt_q <= dly_cnt_d;
      dly_tgt_v_q <= dly_tgt_v_d;
      dly_tgt_q <= dly_tgt_d;
    end
  end

  // Loop count: ordinary register, direct write beats repeat update
  always_comb begin
    loop_count_d = loop_count_q;
    if (lc_wr) begin
      loop_count_d = lc_wdata;
    end else if (lc_rpt_upd) begin
      loop_count_d = lc_rpt_data;
    end
  end

  // Loop count register; direct loads never touch the pipe
  always_ff @(posedge clk) begin
    if (srst) begin
      loop_count_q <= '0;
    end else begin
      loop_count_q <= loop_count_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_wr_hit;
    r_valid_q && d_valid_q && ((r_info_q.wr_grp & d_info_q.use_grp) != 3'h0);
  endsequence

  sequence s_rd_hit;
    r_valid_q && d_valid_q && ((r_info_q.rd_grp & d_info_q.use_grp) != 3'h0) &&
    ((r_info_q.wr_grp & d_info_q.use_grp) == 3'h0);
  endsequence

  sequence s_flush_leaves;
    d_adv && d_info_q.cls == brhz_pkg::cls_flush;
  endsequence

  sequence s_fetch_idle;
    (!fetch_req_q && !d_valid_q) [*2];
  endsequence

  a_wr_two_cycles: assert property (
    s_wr_hit |-> stall ##1 stall ##1 d_adv)
    else $error("group write did not hold decode exactly two cycles");

  a_wr_hold_word: assert property (
    (d_valid_q && wr_hit) |=> d_valid_q && $stable(d_word_q) && !r_valid_q)
    else $error("decode moved past a pending group write");

  a_rd_one_cycle: assert property (
    s_rd_hit |-> stall ##1 d_adv)
    else $error("group read did not delay decode exactly one cycle");

  a_rd_idx_free: assert property (
    (d_valid_q && !wr_hit && r_valid_q && !r_word_q[`BRHZ_RD_AUX] &&
     !r_word_q[`BRHZ_RD_SP] &&
     r_word_q[`BRHZ_OP_MSB:`BRHZ_OP_LSB] != `BRHZ_OP_CDCJD) |-> !stall)
    else $error("index or page pointer read caused a stall");

  a_flush_idle: assert property (
    s_flush_leaves |=> s_fetch_idle ##1 fetch_req_q)
    else $error("flush did not idle fetch for two cycles");

  a_dummy_fetch: assert property (
    (d_valid_q && is_flush(d_info_q.cls) && fetch_req_q) |->
    fetch_dummy_q && (d_info_q.irq || fetch_addr_q == inc_pc(d_pc_q)))
    else $error("dummy fetch not flagged to the cache");

  a_pc_target: assert property (
    (e_flush && !e_info_q.irq && e_info_q.cls == brhz_pkg::cls_flush && br_taken)
    |=> fetch_addr_q == $past(br_target) && fetch_req_q)
    else $error("jump target not used by the next fetch");

  a_delayed_flow: assert property (
    (d_adv && d_info_q.cls == brhz_pkg::cls_delayed && fetch_req_q && pm_ready && !irq_req)
    |=> d_valid_q && !fetch_dummy_q)
    else $error("delayed jump dropped its following word");

  a_lc_direct_wins: assert property (
    (lc_wr && lc_rpt_upd) |=> loop_count_q == $past(lc_wdata))
    else $error("repeat update beat the direct loop count write");

  a_rpt_load: assert property (
    rpt_load_q |-> $past(exec_valid_q && e_info_q.cls == brhz_pkg::cls_repeat))
    else $error("loop registers loaded without a repeat instruction");

  a_pipe_order: assert property (
    d_adv |=> (r_valid_q && r_word_q == $past(d_word_q)) ##1
              (exec_valid_q && exec_word_q == $past(d_word_q, 2)))
    else $error("instruction skipped a pipeline stage");

endmodule

// ---- verif/tb_brhz_ctl.sv ----
// Self-checking testbench of the pipeline controller
`timescale 1ns/100ps
`include "brhz_defines.svh"
module tb_brhz_ctl;
  // Clock, reset and stimulus
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [`BRHZ_WW-1:0] pm_rdata;
  logic pm_ready = 1'b1;
  logic br_taken = 1'b1;
  logic [`BRHZ_AW-1:0] br_target = 24'h000020;
  logic irq_req = 1'b0;
  logic [`BRHZ_AW-1:0] irq_vector = 24'h000030;
  logic lc_wr = 1'b0;
  logic [`BRHZ_LCW-1:0] lc_wdata = 32'h00000000;
  logic lc_rpt_upd = 1'b0;
  logic [`BRHZ_LCW-1:0] lc_rpt_data = 32'h00000000;
  // Observed outputs
  logic fetch_req_q, fetch_dummy_q, exec_valid_q, irq_ack_q, halted_q, rpt_load_q;
  logic [`BRHZ_AW-1:0] fetch_addr_q;
  logic [`BRHZ_WW-1:0] exec_word_q;
  logic [`BRHZ_LCW-1:0] loop_count_q;
  // Program memory and per-cycle logs
  logic [31:0] mem [0:63];
  logic [31:0] ex_w [0:63];
  logic [23:0] fa [0:63];
  logic fq [0:63];
  logic fdm [0:63];
  int cyc = 0;
  int nrpt = 0;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 1452;
  logic [3:0] flush_ops [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};
  logic [3:0] dly_ops [3] = '{4'ha, 4'hb, 4'hc};
  logic [13:0] corner [7] = '{14'h3480, 14'h0090, 14'h0110, 14'h0011, 14'h0012,
    14'h0024, 14'h0048};

  brhz_ctl brhz_ctl_inst (
    .clk(clk), .srst(srst), .pm_rdata(pm_rdata), .pm_ready(pm_ready),
    .fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .fetch_dummy_q(fetch_dummy_q),
    .br_taken(br_taken), .br_target(br_target), .exec_valid_q(exec_valid_q),
    .exec_word_q(exec_word_q), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack_q(irq_ack_q), .halted_q(halted_q), .lc_wr(lc_wr), .lc_wdata(lc_wdata),
    .lc_rpt_upd(lc_rpt_upd), .lc_rpt_data(lc_rpt_data), .rpt_load_q(rpt_load_q),
    .loop_count_q(loop_count_q)
  );

  // Memory answers in the cycle of the fetch
  assign pm_rdata = mem[fetch_addr_q[5:0]];

  // Clock of 10 ns
  initial begin
    forever #5 clk = ~clk;
  end

  // Cycle log since reset release
  always @(posedge clk) begin
    if (srst) begin
      cyc <= 0;
      nrpt <= 0;
      // Forget the previous test's log
      for (int i = 0; i < 64; i++) begin
        ex_w[i] <= 32'hffffffff;
        fa[i] <= 24'hffffff;
        fq[i] <= 1'b0;
        fdm[i] <= 1'b0;
      end
    end else if (cyc < 63) begin
      cyc <= cyc + 1;
      ex_w[cyc] <= (exec_valid_q === 1'b1) ? exec_word_q : 32'hffffffff;
      fa[cyc] <= fetch_addr_q;
      fq[cyc] <= fetch_req_q;
      fdm[cyc] <= fetch_dummy_q;
      nrpt <= nrpt + ((rpt_load_q === 1'b1) ? 1 : 0);
    end
  end

  function automatic logic [31:0] mk(logic [3:0] op, logic [2:0] use_g, logic [2:0] wr_g,
      logic [3:0] rd, logic [7:0] id);
    return {op, use_g, wr_g, rd, 10'h000, id};
  endfunction

  // Expected distance between writer and user execute
  function automatic int stall_gap(logic [3:0] op, logic [2:0] wr, logic [2:0] use_g,
      logic [3:0] rd);
    logic [2:0] u;
    u = (op == `BRHZ_OP_CDJ) ? (use_g | 3'h1) : use_g;
    if ((wr & u) != 3'h0) return 3;
    if ((u[0] & rd[0]) | (u[2] & rd[3])) return 2;
    return 1;
  endfunction

  function automatic int when_exec(logic [31:0] w);
    for (int i = 0; i < 63; i++) begin
      if (ex_w[i] === w) return i;
    end
    return -100;
  endfunction

  // Count of fetch cycles at an address, or of dummy fetches
  function automatic int n_fetch(logic [23:0] a, bit dummy_only);
    int n;
    n = 0;
    for (int i = 0; i < 63; i++) begin
      if (fq[i] === 1'b1 && (dummy_only ? fdm[i] === 1'b1 : fa[i] === a)) n++;
    end
    return n;
  endfunction

  function automatic int first_fetch(logic [23:0] a);
    for (int i = 0; i < 63; i++) begin
      if (fq[i] === 1'b1 && fa[i] === a) return i;
    end
    return -100;
  endfunction

  function automatic bit seen_cond(int which);
    case (which)
      0: return halted_q === 1'b1;
      1: return irq_ack_q === 1'b1;
      default: return fetch_req_q === 1'b1 && fetch_addr_q === irq_vector;
    endcase
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bounded wait for an output event
  task automatic wait_for(int which, int bound);
    int n;
    n = 0;
    while (!seen_cond(which)) begin
      @(posedge clk);
      n++;
      if (n > bound) begin
        num_errors++;
        $display("BAD wait %0d expected event seen none", which);
        report_and_stop();
      end
    end
  endtask

  // Fresh program of plain words, then reset for 3 cycles
  task automatic restart();
    for (int i = 0; i < 64; i++) begin
      mem[i] = mk(`BRHZ_OP_NORMAL, 3'h0, 3'h0, 4'h0, 8'(i));
    end
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic end_test(string name);
    $display("test %s done, mismatches so far %0d", name, num_errors);
  endtask

  initial begin
    logic [31:0] r, wd, ud, exp_q, exp_d;
    logic [13:0] c;
    int t0;
    // Straight run with random loop count traffic
    restart();
    exp_q = 32'h00000000;
    exp_d = 32'h00000000;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      check("loop count", loop_count_q, exp_q);
      exp_q = exp_d;
      r = $random(seed);
      wd = $random(seed);
      ud = $random(seed);
      lc_wr <= r[0];
      lc_rpt_upd <= r[1];
      lc_wdata <= wd;
      lc_rpt_data <= ud;
      exp_d = r[0] ? wd : (r[1] ? ud : exp_d);
    end
    lc_wr <= 1'b0;
    lc_rpt_upd <= 1'b0;
    t0 = when_exec(mem[0]);
    for (int i = 1; i < 12; i++) begin
      check("stream slot", when_exec(mem[i]) - t0, i);
    end
    check("no repeat load", nrpt, 0);
    end_test("stream");
    // Random fetch readiness keeps order
    restart();
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      r = $random(seed);
      pm_ready <= r[0] | r[1];
    end
    pm_ready <= 1'b1;
    for (int i = 1; i < 8; i++) begin
      check("ordered execute", when_exec(mem[i]) > when_exec(mem[i-1]), 1);
    end
    end_test("ready");
    // Flushing branches
    foreach (flush_ops[k]) begin
      restart();
      mem[2] = mk(flush_ops[k], 3'h0, 3'h0, 4'h0, 8'h02);
      repeat (30) @(posedge clk);
      t0 = when_exec(mem[2]);
      check("flush target gap", when_exec(mem[32]) - t0, 4);
      check("flushed word", when_exec(mem[3]), -100);
      check("target fetch", first_fetch(24'h000020) - t0, 1);
      check("dummy count", n_fetch(24'h000000, 1'b1), 1);
      check("dummy addr", first_fetch(24'h000003) - t0, -2);
      check("dummy flag", fdm[first_fetch(24'h000003)], 1);
    end
    end_test("flush");
    // Repeat instructions flush and load once
    for (int k = 6; k < 8; k++) begin
      restart();
      mem[2] = mk(4'(k), 3'h0, 3'h0, 4'h0, 8'h02);
      repeat (30) @(posedge clk);
      t0 = when_exec(mem[2]);
      check("repeat resume gap", when_exec(mem[3]) - t0, 4);
      check("repeat load pulses", nrpt, 1);
    end
    end_test("repeat");
    // Delayed branches run three words then the target
    foreach (dly_ops[k]) begin
      restart();
      mem[2] = mk(dly_ops[k], 3'h0, 3'h0, 4'h0, 8'h02);
      repeat (30) @(posedge clk);
      t0 = when_exec(mem[2]);
      for (int i = 1; i < 4; i++) begin
        check("delay slot", when_exec(mem[2+i]) - t0, i);
      end
      check("delayed target", when_exec(mem[32]) - t0, 4);
      check("not in slot", when_exec(mem[6]), -100);
      check("no dummy", n_fetch(24'h000000, 1'b1), 0);
    end
    end_test("delayed");
    // Register group stalls, corners then random
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      c = (k < 7) ? corner[k] : {4'h0, r[9:0]};
      restart();
      mem[1] = mk(`BRHZ_OP_NORMAL, 3'h0, c[9:7], c[3:0], 8'h01);
      mem[2] = mk(c[13:10], c[6:4], 3'h0, 4'h0, 8'h02);
      repeat (30) @(posedge clk);
      t0 = stall_gap(c[13:10], c[9:7], c[6:4], c[3:0]);
      check("stall gap", when_exec(mem[2]) - when_exec(mem[1]), t0);
      if (c[13:10] == `BRHZ_OP_NORMAL) begin
        check("refetch count", n_fetch(24'h000003, 1'b0), t0);
      end
    end
    end_test("stall");
    // Interrupt in a stream, then halt released by interrupt
    restart();
    mem[49] = mk(`BRHZ_OP_HALT, 3'h0, 3'h0, 4'h0, 8'h31);
    irq_req <= 1'b1;
    wait_for(1, 12);
    irq_req <= 1'b0;
    wait_for(2, 8);
    check("vector fetch", fetch_addr_q, irq_vector);
    wait_for(0, 20);
    repeat (4) begin
      @(posedge clk);
      check("halted fetch", fetch_req_q, 0);
    end
    irq_req <= 1'b1;
    wait_for(1, 12);
    irq_req <= 1'b0;
    wait_for(2, 8);
    @(posedge clk);
    check("halt released", halted_q, 0);
    end_test("interrupt");
    report_and_stop();
  end
endmodule
